// ==== logic/dbgack_handshake.sv ====
`timescale 1ns/1ps
module dbgack_handshake (
   input  wire logic                       clk_i,
   input  wire logic                       srst_i,
   input  wire logic                       sclk_tick_i,
   input  wire logic                       dbg_en_i,
   input  wire logic                       ack_en_i,
   input  wire dbgack_pkg::dbgack_cmd_end_t cmd_end_i,
   input  wire logic                       grant_i,
   input  wire logic                       low_power_entry_i,
   input  wire logic                       pin_i,
   output logic                            pin_o,
   output logic                            pin_oe_o,
   output logic                            access_req_o,
   output logic                            access_timeout_flag_o,
   output logic                            resync_o,
   output logic                            done_o
);
   typedef enum logic [2:0] {
      S_IDLE, S_WAIT, S_ACCESS, S_LOW, S_SPEED, S_RESYNC
   } dbgack_state_t;

   dbgack_state_t state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [7:0] low_ff, nxt_low;
   logic [7:0] len_ff, nxt_len;
   logic [9:0] tmo_ff, nxt_tmo;
   logic       err_ff, nxt_err;
   logic       lp_ff, nxt_lp;
   logic       tof_ff, nxt_tof;
   logic       send_ff, nxt_send;
   logic       pin_ff, nxt_pin;
   logic       oe_ff, nxt_oe;
   logic       req_ff, nxt_req;
   logic       rs_ff, nxt_rs;
   logic       done_ff, nxt_done;
   logic       abort_seen;

   // Abort: the host holds the released wire low for the minimum length
   assign abort_seen = sclk_tick_i && !pin_i && !oe_ff &&
                       (low_ff == dbgack_pkg::ABORT_LOW_MIN - dbgack_pkg::CNT_ONE);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_len   = len_ff;
      nxt_tmo   = tmo_ff;
      nxt_err   = err_ff;
      nxt_lp    = lp_ff;
      nxt_tof   = tof_ff;
      nxt_send  = send_ff;
      nxt_pin   = 1'b1;
      nxt_oe    = 1'b0;
      nxt_req   = req_ff;
      nxt_rs    = 1'b0;
      nxt_done  = 1'b0;
      nxt_low   = low_ff;
      if (sclk_tick_i) begin
         if (pin_i || oe_ff) begin
            nxt_low = dbgack_pkg::CNT_ZERO;
         end else if (low_ff != dbgack_pkg::ABORT_LOW_MIN) begin
            nxt_low = low_ff + dbgack_pkg::CNT_ONE;
         end
      end
      case (state_ff)
         S_IDLE: begin
            if (cmd_end_i.valid) begin
               nxt_cnt  = dbgack_pkg::CNT_ZERO;
               nxt_err  = cmd_end_i.error;
               nxt_tof  = 1'b0;
               nxt_send = ack_en_i && (cmd_end_i.kind != dbgack_pkg::DBGACK_CMD_STATUS);
               if (cmd_end_i.kind == dbgack_pkg::DBGACK_CMD_ACCESS) begin
                  nxt_tmo   = dbgack_pkg::TMO_ZERO;
                  nxt_req   = 1'b1;
                  nxt_state = S_ACCESS;
               end else begin
                  nxt_state = S_WAIT;
               end
            end
         end
         S_ACCESS: begin
            nxt_tmo = tmo_ff + dbgack_pkg::TMO_ONE;
            if (sclk_tick_i && cnt_ff != dbgack_pkg::ACK_MIN_DLY) begin
               nxt_cnt = cnt_ff + dbgack_pkg::CNT_ONE;
            end
            if (grant_i) begin
               nxt_req   = 1'b0;
               nxt_state = S_WAIT;
            end else if (tmo_ff == dbgack_pkg::GRANT_TMO - dbgack_pkg::TMO_ONE) begin
               // No grant in time: give up and answer with an error
               nxt_req   = 1'b0;
               nxt_tof   = 1'b1;
               nxt_err   = 1'b1;
               nxt_send  = 1'b1;
               nxt_state = S_WAIT;
            end
         end
         S_WAIT: begin
            if (sclk_tick_i) begin
               nxt_cnt = cnt_ff + dbgack_pkg::CNT_ONE;
               if (!send_ff && cnt_ff >= dbgack_pkg::NOACK_DLY - dbgack_pkg::CNT_ONE) begin
                  nxt_done  = 1'b1;
                  nxt_state = S_IDLE;
               end else if (send_ff &&
                            cnt_ff >= dbgack_pkg::ACK_MIN_DLY - dbgack_pkg::CNT_ONE) begin
                  nxt_cnt   = dbgack_pkg::CNT_ZERO;
                  nxt_len   = (err_ff || lp_ff) ? dbgack_pkg::LONG_ACK_LEN
                                                : dbgack_pkg::SHORT_ACK_LEN;
                  nxt_lp    = 1'b0;
                  nxt_pin   = 1'b0;
                  nxt_oe    = 1'b1;
                  nxt_state = S_LOW;
               end
            end
         end
         S_LOW: begin
            nxt_pin = 1'b0;
            nxt_oe  = 1'b1;
            if (sclk_tick_i) begin
               nxt_cnt = cnt_ff + dbgack_pkg::CNT_ONE;
               if (cnt_ff == len_ff - dbgack_pkg::CNT_ONE) begin
                  nxt_cnt   = dbgack_pkg::CNT_ZERO;
                  nxt_pin   = 1'b1;
                  nxt_state = S_SPEED;
               end
            end
         end
         S_SPEED: begin
            nxt_oe = 1'b1;
            if (sclk_tick_i) begin
               nxt_cnt = cnt_ff + dbgack_pkg::CNT_ONE;
               if (cnt_ff == dbgack_pkg::SPEEDUP_LEN - dbgack_pkg::CNT_ONE) begin
                  nxt_oe    = 1'b0;
                  nxt_done  = 1'b1;
                  nxt_state = S_IDLE;
               end
            end
         end
         S_RESYNC: begin
            // Wait for the host to release the wire, then answer with a long low
            if (oe_ff) begin
               nxt_pin = 1'b0;
               nxt_oe  = 1'b1;
               if (sclk_tick_i) begin
                  nxt_cnt = cnt_ff + dbgack_pkg::CNT_ONE;
                  if (cnt_ff == dbgack_pkg::RESYNC_LEN - dbgack_pkg::CNT_ONE) begin
                     nxt_cnt   = dbgack_pkg::CNT_ZERO;
                     nxt_pin   = 1'b1;
                     nxt_state = S_SPEED;
                  end
               end
            end else if (pin_i && sclk_tick_i) begin
               nxt_cnt = dbgack_pkg::CNT_ZERO;
               nxt_pin = 1'b0;
               nxt_oe  = 1'b1;
            end
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
      // Set after the case so that a new entry wins over the clear of an answer
      if (dbg_en_i && low_power_entry_i) begin
         nxt_lp = 1'b1;
      end
      // An abort outside S_RESYNC overrides the pending request and answer
      if (abort_seen && state_ff != S_RESYNC) begin
         nxt_req   = 1'b0;
         nxt_send  = 1'b0;
         nxt_rs    = 1'b1;
         nxt_cnt   = dbgack_pkg::CNT_ZERO;
         nxt_pin   = 1'b1;
         nxt_oe    = 1'b0;
         nxt_state = S_RESYNC;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_ff <= S_IDLE;
         cnt_ff   <= dbgack_pkg::CNT_ZERO;
         low_ff   <= dbgack_pkg::CNT_ZERO;
         len_ff   <= dbgack_pkg::CNT_ZERO;
         tmo_ff   <= dbgack_pkg::TMO_ZERO;
         err_ff   <= 1'b0;
         lp_ff    <= 1'b0;
         tof_ff   <= 1'b0;
         send_ff  <= 1'b0;
         pin_ff   <= 1'b1;
         oe_ff    <= 1'b0;
         req_ff   <= 1'b0;
         rs_ff    <= 1'b0;
         done_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         low_ff   <= nxt_low;
         len_ff   <= nxt_len;
         tmo_ff   <= nxt_tmo;
         err_ff   <= nxt_err;
         lp_ff    <= nxt_lp;
         tof_ff   <= nxt_tof;
         send_ff  <= nxt_send;
         pin_ff   <= nxt_pin;
         oe_ff    <= nxt_oe;
         req_ff   <= nxt_req;
         rs_ff    <= nxt_rs;
         done_ff  <= nxt_done;
      end
   end

   assign pin_o                 = pin_ff;
   assign pin_oe_o              = oe_ff;
   assign access_req_o          = req_ff;
   assign access_timeout_flag_o = tof_ff;
   assign resync_o              = rs_ff;
   assign done_o                = done_ff;
endmodule

// ==== logic/dbgack_pkg.sv ====
// Functional notes
// - Status-returning commands get no acknowledge
// - Error gives 64-cycle low pulse plus speedup
// - Acknowledge starts at least 32 cycles after command
// - Acknowledge disabled uses 16-cycle delay instead
// - Access not granted in 512 cycles aborts, flags
// - First acknowledge after stop/wait is long if dbg_en_i is set at the entry
// - Long low pulse resynchronises, cancels pending command
package dbgack_pkg;
   localparam int unsigned CNT_W        = 8;
   localparam logic [7:0]  ACK_MIN_DLY  = 8'h20;
   localparam logic [7:0]  NOACK_DLY    = 8'h10;
   localparam logic [7:0]  LONG_ACK_LEN = 8'h40;
   localparam logic [7:0]  SHORT_ACK_LEN = 8'h10;
   localparam logic [7:0]  SPEEDUP_LEN  = 8'h01;
   localparam logic [7:0]  ABORT_LOW_MIN = 8'h80;
   localparam logic [7:0]  RESYNC_LEN   = 8'h80;
   localparam logic [9:0]  GRANT_TMO    = 10'h200;
   localparam logic [7:0]  CNT_ONE      = 8'h01;
   localparam logic [9:0]  TMO_ONE      = 10'h001;
   localparam logic [7:0]  CNT_ZERO     = 8'h00;
   localparam logic [9:0]  TMO_ZERO     = 10'h000;

   typedef enum logic [1:0] {
      DBGACK_CMD_PLAIN,
      DBGACK_CMD_STATUS,
      DBGACK_CMD_ACCESS
   } dbgack_cmd_t;

   typedef struct packed {
      logic        valid;
      dbgack_cmd_t kind;
      logic        error;
   } dbgack_cmd_end_t;

   typedef struct packed {
      logic drv;
      logic oe;
   } dbgack_pin_t;
endpackage

// ==== sim/dbgack_props.sv ====
`timescale 1ns/1ps
module dbgack_props (
   input wire logic                        clk_i,
   input wire logic                        srst_i,
   input wire logic                        sclk_tick_i,
   input wire logic                        dbg_en_i,
   input wire logic                        ack_en_i,
   input wire logic                        grant_i,
   input wire dbgack_pkg::dbgack_cmd_end_t cmd_end_i,
   input wire logic                        low_power_entry_i,
   input wire logic                        pin_i,
   input wire logic                        pin_o,
   input wire logic                        pin_oe_o,
   input wire logic                        access_req_o,
   input wire logic                        access_timeout_flag_o,
   input wire logic                        resync_o,
   input wire logic                        done_o
);
   logic [7:0] since_ff, low_ff;
   logic [9:0] wait_ff;
   logic       lng_ff, rs_ff;
   // Ticks since command end, driven low length, access wait, long-ack and resync pending
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         since_ff <= 8'hFF;
         low_ff <= 8'h00;
         wait_ff <= 10'h000;
         lng_ff <= 1'b0;
         rs_ff <= 1'b0;
      end else begin
         if (cmd_end_i.valid) since_ff <= 8'h00;
         else if (sclk_tick_i && since_ff != 8'hFF) since_ff <= since_ff + 8'h01;
         low_ff <= (pin_oe_o && !pin_o) ? low_ff + {7'h00, sclk_tick_i} : 8'h00;
         wait_ff <= cmd_end_i.valid ? 10'h000 : wait_ff + {9'h000, access_req_o};
         if (cmd_end_i.valid && cmd_end_i.error || low_power_entry_i && dbg_en_i
             || $rose(access_timeout_flag_o)) lng_ff <= 1'b1;
         else if (done_o) lng_ff <= 1'b0;
         if (resync_o) rs_ff <= 1'b1;
         else if (cmd_end_i.valid) rs_ff <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence silent_s; (!pin_oe_o) [*8] ##[6:10] done_o; endsequence
   sequence ack_end_s; $rose(pin_o) && pin_oe_o; endsequence
   ack_gap_a: assert property (
      $rose(pin_oe_o) && !rs_ff |-> since_ff >= 8'h20) else $error("ack started early");
   no_ack_a: assert property (
      cmd_end_i.valid && !ack_en_i && !cmd_end_i.error
      && cmd_end_i.kind == dbgack_pkg::DBGACK_CMD_PLAIN |=> silent_s) else $error("no-ack delay");
   status_quiet_a: assert property (
      cmd_end_i.valid && !cmd_end_i.error
      && cmd_end_i.kind == dbgack_pkg::DBGACK_CMD_STATUS |=> silent_s) else $error("status ack");
   long_ack_a: assert property (
      ack_end_s and lng_ff && !rs_ff |-> low_ff == 8'h40) else $error("long ack length");
   short_ack_a: assert property (
      ack_end_s and !lng_ff && !rs_ff |-> low_ff == 8'h10) else $error("short ack length");
   grant_timeout_a: assert property (
      $rose(access_timeout_flag_o) |-> wait_ff inside {[10'h1FF:10'h201]}) else $error("timeout");
   abort_cancel_a: assert property (
      resync_o |-> ##[1:2] !access_req_o) else $error("abort kept request");
   resync_ans_a: assert property (
      ack_end_s and rs_ff |-> low_ff == 8'h80) else $error("resync answer length");
endmodule
bind dbgack_handshake dbgack_props u_props (
   .clk_i                 (clk_i),
   .srst_i                (srst_i),
   .sclk_tick_i           (sclk_tick_i),
   .dbg_en_i              (dbg_en_i),
   .ack_en_i              (ack_en_i),
   .grant_i               (grant_i),
   .cmd_end_i             (cmd_end_i),
   .low_power_entry_i     (low_power_entry_i),
   .pin_i                 (pin_i),
   .pin_o                 (pin_o),
   .pin_oe_o              (pin_oe_o),
   .access_req_o          (access_req_o),
   .access_timeout_flag_o (access_timeout_flag_o),
   .resync_o              (resync_o),
   .done_o                (done_o)
);

// ==== sim/dbgack_host.sv ====
`timescale 1ns/1ps
module dbgack_host (
   input  wire logic clk_i,
   input  wire logic pin_o,
   input  wire logic pin_oe_o,
   input  wire logic abort_i,
   output logic      pin_i,
   output logic      busy_o
);
   logic [7:0] cnt_ff = 8'h00;
   // Abort: 130 ticks low, a small margin over the minimum, then one high tick
   always_ff @(posedge clk_i) begin
      if (abort_i && !busy_o) cnt_ff <= 8'h83;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
   end
   assign busy_o = cnt_ff != 8'h00;
   // Released wire idles high through its pull-up
   assign pin_i = pin_oe_o ? pin_o : !(cnt_ff > 8'h01);
endmodule

// ==== sim/debug_ack_handshake_abort_tb_top.sv ====
`timescale 1ns/1ps
module debug_ack_handshake_abort_tb_top;
   logic clk_i = 1'b0, srst_i = 1'b1, sclk_tick_i = 1'b1, dbg_en_i = 1'b1, ack_en_i = 1'b1;
   logic grant_i = 1'b0, low_power_entry_i = 1'b0, abort = 1'b0;
   dbgack_pkg::dbgack_cmd_end_t cmd_end_i = '0;
   logic pin_i, pin_o, pin_oe_o, access_req_o, access_timeout_flag_o, resync_o, done_o, busy;
   logic [7:0] exp_q[$];
   logic [7:0] len = 8'h00;
   int fail_count = 0, checks = 0, cyc = 0;
   always #5 clk_i = ~clk_i;
   dbgack_handshake DUT (.clk_i(clk_i), .srst_i(srst_i), .sclk_tick_i(sclk_tick_i),
      .dbg_en_i(dbg_en_i), .ack_en_i(ack_en_i), .cmd_end_i(cmd_end_i), .grant_i(grant_i),
      .low_power_entry_i(low_power_entry_i), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .access_req_o(access_req_o),
      .access_timeout_flag_o(access_timeout_flag_o), .resync_o(resync_o), .done_o(done_o));
   dbgack_host HOST (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .abort_i(abort),
      .pin_i(pin_i), .busy_o(busy));
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      if (fail_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Measures the driven low time of each answer and compares it at completion
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         end_sim();
      end
      len <= cmd_end_i.valid ? 8'h00 : len + {7'h00, pin_oe_o && !pin_o};
      if (done_o === 1'b1 && exp_q.size() > 0) begin
         check("ack_low", exp_q.pop_front(), len);
      end
   end
   task automatic send(input logic [1:0] k, input logic e);
      cmd_end_i = '{1'b1, dbgack_pkg::dbgack_cmd_t'(k), e};
      @(posedge clk_i) #1;
      cmd_end_i.valid = 1'b0;
   endtask
   // One command at a time: wait for completion before the next
   task automatic cmd(input logic [1:0] k, input logic e, input logic [7:0] x);
      int n;
      exp_q.push_back(x);
      send(k, e);
      for (n = 0; n < 1000 && done_o !== 1'b1; n++) @(posedge clk_i) #1;
      @(posedge clk_i) #1;
   endtask
   initial begin
      logic [1:0] k;
      logic       e;
      int         n;
      void'($urandom(32'h1C1E));
      repeat (10) @(posedge clk_i);
      #1 srst_i = 1'b0;
      repeat (12) begin
         k = {1'b0, 1'($urandom)};
         ack_en_i = 1'($urandom);
         e = 1'($urandom) & ack_en_i & !k[0];
         cmd(k, e, (k[0] || !ack_en_i) ? 8'h00 : (e ? 8'h40 : 8'h10));
      end
      ack_en_i = 1'b1;
      low_power_entry_i = 1'b1;
      @(posedge clk_i) #1;
      low_power_entry_i = 1'b0;
      cmd(2'h0, 1'b0, 8'h40);
      dbg_en_i = 1'b0;
      low_power_entry_i = 1'b1;
      @(posedge clk_i) #1;
      low_power_entry_i = 1'b0;
      dbg_en_i = 1'b1;
      cmd(2'h0, 1'b0, 8'h10);
      grant_i = 1'b1;
      cmd(2'h2, 1'b0, 8'h10);
      grant_i = 1'b0;
      cmd(2'h2, 1'b0, 8'h40);
      check("timeout_flag", 8'h01, {7'h00, access_timeout_flag_o});
      send(2'h2, 1'b0);
      repeat (40) @(posedge clk_i) #1;
      abort = 1'b1;
      @(posedge clk_i) #1;
      abort = 1'b0;
      for (n = 0; n < 300 && resync_o !== 1'b1; n++) @(posedge clk_i) #1;
      check("resync", 8'h01, {7'h00, resync_o});
      repeat (300) @(posedge clk_i) #1;
      check("access_req", 8'h00, {7'h00, access_req_o});
      cmd(2'h0, 1'b0, 8'h10);
      end_sim();
   end
endmodule
